// File: tbc_pkg.sv
package tbc_pkg;

  // ---------------------------------------------------------------
  // register word indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [3:0] IX_CTLA = 4'h0;
  localparam logic [3:0] IX_CTLB = 4'h1;
  localparam logic [3:0] IX_CNTL = 4'h2;
  localparam logic [3:0] IX_CNTH = 4'h3;
  localparam logic [3:0] IX_CAL = 4'h4;
  localparam logic [3:0] IX_CAH = 4'h5;
  localparam logic [3:0] IX_CBL = 4'h6;
  localparam logic [3:0] IX_CBH = 4'h7;
  localparam logic [3:0] IX_CPL = 4'h8;
  localparam logic [3:0] IX_CPH = 4'h9;
  localparam logic [3:0] IX_FLG = 4'ha;
  localparam logic [3:0] IX_MSK = 4'hb;
  localparam logic [3:0] IX_NONE = 4'hf;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 5;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ---------------------------------------------------------------
  // field positions, flag bits and codes
  // ---------------------------------------------------------------
  localparam int CA_WGM = 0;
  localparam int CA_COMB = 4;
  localparam int CA_COMA = 6;
  localparam int CB_CS = 0;
  localparam int CB_WGM = 3;
  localparam int CB_SRC = 5;
  localparam int CB_EDGE = 6;
  localparam int CB_FILT = 7;
  localparam int FL_OVF = 0;
  localparam int FL_CMA = 1;
  localparam int FL_CMB = 2;
  localparam int FL_CAP = 3;
  localparam logic [15:0] LOWEST_COUNT = 16'h0000;
  localparam logic [15:0] MAX_COUNT = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_IO = 3'h1;
  localparam logic [2:0] CS_8 = 3'h2;
  localparam logic [2:0] CS_64 = 3'h3;
  localparam logic [2:0] CS_256 = 3'h4;
  localparam logic [2:0] CS_1024 = 3'h5;
  localparam logic [2:0] CS_FALL = 3'h6;
  localparam logic [2:0] CS_RISE = 3'h7;
  localparam logic [1:0] COM_TGL = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam int PSC_W = 10;
  localparam int FILT_LEN = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR = 3'b010,
    BUS_RD = 3'b100
  } tbc_bus_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } tbc_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } tbc_ahb_rsp_t;

  typedef struct packed {
    tbc_bus_t bus;
    logic [3:0] idx;
    logic hready;
    logic [7:0] hrdata;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] temp;
    logic [15:0] count;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b_buf;
    logic [15:0] cmp_b;
    logic [15:0] capture;
    logic up;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [PSC_W-1:0] presc;
    logic ext_prev;
    logic [FILT_LEN-1:0] cap_hist;
    logic cap_lvl;
    logic wave_a;
    logic wave_b;
    logic irq;
  } tbc_state_t;

  localparam tbc_state_t ST_RESET = '{bus: BUS_IDLE, hready: 1'b1, up: 1'b1, default: '0};

  // ---------------------------------------------------------------
  // mode decoding
  // ---------------------------------------------------------------
  function automatic logic [3:0] mode_of(input logic [7:0] ca, input logic [7:0] cb);
    mode_of = {cb[CB_WGM+:2], ca[CA_WGM+:2]};
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m[3:2] == 2'h2) || (m[3:2] == 2'h0 && m != 4'h0);
  endfunction

  function automatic logic ca_top(input logic [3:0] m);
    ca_top = (m == 4'h4 || m == 4'h9 || m == 4'hb || m == 4'hf);
  endfunction

  function automatic logic cap_top(input logic [3:0] m);
    cap_top = (m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca, input logic [15:0] cp);
    case (m)
      4'h1, 4'h5: top_of = TOP_8;
      4'h2, 4'h6: top_of = TOP_9;
      4'h3, 4'h7: top_of = TOP_10;
      default: top_of = ca_top(m) ? ca : (cap_top(m) ? cp : MAX_COUNT);
    endcase
  endfunction

endpackage

// File: tbc_timer16.sv
// What this block does
// - sixteen-bit registers reached as two byte accesses
// - one shared high-byte latch for all
// - low-byte write loads latch plus low byte
// - low-byte read copies upper byte into latch
// - compare reads bypass the shared latch
// - count only on selected tick, else idle
// - compare matches set flags, drive waveforms
// - compare values double buffered in PWM, PWM A-top leaves channel A toggle only
// - qualified capture edge stores count, optional filter
// - lowest count zero, maximum all ones
// - top is fixed, compare A or capture
// - four flags, each gated by mask bit
// - control registers plain byte access
// - software counter write beats count or clear
// - capture flag set with capture store
`timescale 1ns/10ps

module tbc_timer16 (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire tbc_pkg::tbc_ahb_req_t ahb_req,
  output tbc_pkg::tbc_ahb_rsp_t ahb_rsp,
  // timer pins
  input wire logic external_tick_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  output logic wave_out_a,
  output logic wave_out_b,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tbc_pkg::tbc_state_t s;
  tbc_pkg::tbc_state_t n;
  logic [3:0] mode;

  // first address bit above the register map, all must be zero to hit
  localparam int ADDR_TOP = tbc_pkg::ADDR_MSB + 1;

  assign mode = tbc_pkg::mode_of(s.ctl_a, s.ctl_b);

  // outputs straight from the state flops
  assign ahb_rsp = '{hrdata: {24'h000000, s.hrdata}, hreadyout: s.hready, hresp: 1'b0};
  assign wave_out_a = s.wave_a;
  assign wave_out_b = s.wave_b;
  assign irq = s.irq;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] top;
    logic tk;
    logic pwm;
    logic dual;
    logic at_top;
    logic at_bot;
    logic ma;
    logic mb;
    logic acc;
    logic src;
    logic lvl;
    logic [1:0] com_a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [3:0] set_f;
    logic [3:0] clr_f;
    n = s;
    top = tbc_pkg::top_of(mode, s.cmp_a, s.capture);
    pwm = tbc_pkg::is_pwm(mode);
    dual = tbc_pkg::is_dual(mode);
    at_top = (s.count == top);
    at_bot = (s.count == tbc_pkg::LOWEST_COUNT);
    ma = (s.count == s.cmp_a);
    mb = (s.count == s.cmp_b);
    wd = ahb_req.hwdata[7:0];
    rd = 8'h00;
    set_f = 4'h0;
    clr_f = 4'h0;
    src = s.ctl_b[tbc_pkg::CB_SRC] ? comparator_output : capture_input_pin;
    lvl = src;
    tk = 1'b0;
    com_a = s.ctl_a[tbc_pkg::CA_COMA+:2];
    acc = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

    // tick source: free prescaler or pin edge, nothing when stopped
    n.presc = s.presc + {{(tbc_pkg::PSC_W-1){1'b0}}, 1'b1};
    n.ext_prev = external_tick_pin;
    case (s.ctl_b[tbc_pkg::CB_CS+:3])
      tbc_pkg::CS_IO: tk = 1'b1;
      tbc_pkg::CS_8: tk = &s.presc[2:0];
      tbc_pkg::CS_64: tk = &s.presc[5:0];
      tbc_pkg::CS_256: tk = &s.presc[7:0];
      tbc_pkg::CS_1024: tk = &s.presc;
      tbc_pkg::CS_FALL: tk = s.ext_prev & ~external_tick_pin;
      tbc_pkg::CS_RISE: tk = ~s.ext_prev & external_tick_pin;
      default: tk = 1'b0;
    endcase

    // channel A is the period source in its PWM modes: toggle only
    if (pwm && tbc_pkg::ca_top(mode) && com_a != tbc_pkg::COM_TGL) begin
      com_a = 2'h0;
    end

    // ---------------------------------------------------------------
    // counter unit
    // ---------------------------------------------------------------
    if (tk) begin
      if (dual) begin
        if (s.up && at_top) begin
          n.count = s.count - 16'h0001;
          n.up = 1'b0;
        end else if (!s.up && at_bot) begin
          n.count = s.count + 16'h0001;
          n.up = 1'b1;
          set_f[tbc_pkg::FL_OVF] = 1'b1;
        end else begin
          n.count = s.up ? s.count + 16'h0001 : s.count - 16'h0001;
        end
      end else begin
        n.count = at_top ? tbc_pkg::LOWEST_COUNT : s.count + 16'h0001;
        // fast pwm overflows at top, others at the absolute maximum
        if (pwm ? at_top : s.count == tbc_pkg::MAX_COUNT) begin
          set_f[tbc_pkg::FL_OVF] = 1'b1;
        end
      end
      // continuous compare on each tick
      set_f[tbc_pkg::FL_CMA] = ma;
      set_f[tbc_pkg::FL_CMB] = mb;
      n.wave_a = wave_next(com_a, pwm, dual, s.up, ma, at_top, s.wave_a);
      n.wave_b = wave_next(s.ctl_a[tbc_pkg::CA_COMB+:2], pwm, dual, s.up, mb, at_top, s.wave_b);
      // buffered compare values move in at top, so no glitch mid period
      if (pwm && at_top && (s.up || !dual)) begin
        n.cmp_a = s.cmp_a_buf;
        n.cmp_b = s.cmp_b_buf;
      end
    end

    // ---------------------------------------------------------------
    // capture unit
    // ---------------------------------------------------------------
    n.cap_hist = {s.cap_hist[tbc_pkg::FILT_LEN-2:0], src};
    if (s.ctl_b[tbc_pkg::CB_FILT]) begin
      // level only moves after a run of equal samples
      lvl = (&s.cap_hist) ? 1'b1 : ((~|s.cap_hist) ? 1'b0 : s.cap_lvl);
    end
    n.cap_lvl = lvl;
    // capture is off while the capture register sets the period
    if (lvl != s.cap_lvl && lvl == s.ctl_b[tbc_pkg::CB_EDGE] && !tbc_pkg::cap_top(mode)) begin
      n.capture = s.count;
      set_f[tbc_pkg::FL_CAP] = 1'b1;
    end

    // ---------------------------------------------------------------
    // bus address phase: reads get one wait state
    // ---------------------------------------------------------------
    n.bus = tbc_pkg::BUS_IDLE;
    n.hready = 1'b1;
    if (s.bus != tbc_pkg::BUS_RD && acc) begin
      n.bus = ahb_req.hwrite ? tbc_pkg::BUS_WR : tbc_pkg::BUS_RD;
      n.hready = ahb_req.hwrite;
      n.idx = tbc_pkg::IX_NONE;
      if (ahb_req.haddr[31:ADDR_TOP] == '0 && ahb_req.hsize == tbc_pkg::HSIZE_WORD &&
          ahb_req.haddr[1:0] == 2'h0 && ahb_req.haddr[tbc_pkg::ADDR_MSB:tbc_pkg::ADDR_LSB] <= tbc_pkg::IX_MSK) begin
        n.idx = ahb_req.haddr[tbc_pkg::ADDR_MSB:tbc_pkg::ADDR_LSB];
      end
    end

    // ---------------------------------------------------------------
    // write data phase, placed after the counter and capture units so it overrides the counter
    // ---------------------------------------------------------------
    if (s.bus == tbc_pkg::BUS_WR) begin
      case (s.idx)
        tbc_pkg::IX_CTLA: n.ctl_a = wd;
        tbc_pkg::IX_CTLB: n.ctl_b = wd;
        // high bytes only fill the shared latch
        tbc_pkg::IX_CNTH, tbc_pkg::IX_CAH, tbc_pkg::IX_CBH, tbc_pkg::IX_CPH: begin
          n.temp = wd;
        end
        tbc_pkg::IX_CNTL: begin
          n.count = {s.temp, wd};
        end
        tbc_pkg::IX_CAL: n.cmp_a_buf = {s.temp, wd};
        tbc_pkg::IX_CBL: n.cmp_b_buf = {s.temp, wd};
        tbc_pkg::IX_CPL: begin
          if (tbc_pkg::cap_top(mode)) begin
            n.capture = {s.temp, wd};
          end
        end
        tbc_pkg::IX_MSK: n.mask = wd[3:0];
        default: ;
      endcase
    end

    // outside pwm the compare value takes effect at once
    if (!pwm) begin
      n.cmp_a = n.cmp_a_buf;
      n.cmp_b = n.cmp_b_buf;
    end

    // ---------------------------------------------------------------
    // read data phase, second cycle
    // ---------------------------------------------------------------
    if (s.bus == tbc_pkg::BUS_RD) begin
      case (s.idx)
        tbc_pkg::IX_CTLA: rd = s.ctl_a;
        tbc_pkg::IX_CTLB: rd = s.ctl_b;
        tbc_pkg::IX_CNTL: begin
          rd = s.count[7:0];
          n.temp = s.count[15:8];
        end
        tbc_pkg::IX_CPL: begin
          rd = s.capture[7:0];
          n.temp = s.capture[15:8];
        end
        tbc_pkg::IX_CNTH, tbc_pkg::IX_CPH: rd = s.temp;
        tbc_pkg::IX_CAL: rd = s.cmp_a_buf[7:0];
        tbc_pkg::IX_CAH: rd = s.cmp_a_buf[15:8];
        tbc_pkg::IX_CBL: rd = s.cmp_b_buf[7:0];
        tbc_pkg::IX_CBH: rd = s.cmp_b_buf[15:8];
        tbc_pkg::IX_FLG: begin
          rd = {4'h0, s.flags};
          clr_f = s.flags;
        end
        tbc_pkg::IX_MSK: rd = {4'h0, s.mask};
        default: rd = 8'h00;
      endcase
      n.hrdata = rd;
    end

    // an event in the clearing cycle survives the read
    n.flags = (s.flags & ~clr_f) | set_f;
    n.irq = |(n.flags & n.mask);
  end

  // ---------------------------------------------------------------
  // waveform output per channel
  // ---------------------------------------------------------------
  function automatic logic wave_next(input logic [1:0] com, input logic pwm, input logic dual,
                                     input logic up, input logic m, input logic top, input logic cur);
    logic r;
    r = cur;
    case (com)
      tbc_pkg::COM_TGL: r = m ? ~cur : cur;
      tbc_pkg::COM_CLR, tbc_pkg::COM_SET: begin
        if (!pwm) begin
          r = m ? (com == tbc_pkg::COM_SET) : cur;
        end else if (!dual) begin
          r = top ? (com == tbc_pkg::COM_CLR) : (m ? (com == tbc_pkg::COM_SET) : cur);
        end else begin
          r = m ? (up ? (com == tbc_pkg::COM_SET) : (com == tbc_pkg::COM_CLR)) : cur;
        end
      end
      default: r = cur;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= tbc_pkg::ST_RESET;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb_chk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic cnt_wr;
  logic tick_io;
  assign cnt_wr = (s.bus == tbc_pkg::BUS_WR) && (s.idx == tbc_pkg::IX_CNTL);
  assign tick_io = (s.ctl_b[tbc_pkg::CB_CS+:3] == tbc_pkg::CS_IO);

  property p_low_write;
    cnt_wr |=> s.count == {$past(s.temp), $past(ahb_req.hwdata[7:0])};
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("counter low write did not load latch and byte");

  property p_high_write;
    s.bus == tbc_pkg::BUS_WR && s.idx == tbc_pkg::IX_CAH
      |=> s.cmp_a_buf == $past(s.cmp_a_buf) && s.temp == $past(ahb_req.hwdata[7:0]);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high byte write disturbed target or missed latch");

  property p_low_read;
    s.bus == tbc_pkg::BUS_RD && s.idx == tbc_pkg::IX_CNTL
      |=> s.temp == $past(s.count[15:8]) && ahb_rsp.hrdata[7:0] == $past(s.count[7:0]);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low byte read did not copy upper byte");

  property p_cmp_read;
    s.bus == tbc_pkg::BUS_RD && (s.idx == tbc_pkg::IX_CAH || s.idx == tbc_pkg::IX_CBH)
      |=> s.temp == $past(s.temp) && ahb_rsp.hreadyout;
  endproperty
  a_cmp_read: assert property (p_cmp_read)
    else $error("compare read touched the latch");

  property p_stop;
    s.ctl_b[tbc_pkg::CB_CS+:3] == tbc_pkg::CS_STOP && !cnt_wr |=> $stable(s.count);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved with no tick source");

  property p_cap_flag;
    s.bus != tbc_pkg::BUS_WR ##1 $changed(s.capture) |-> s.flags[tbc_pkg::FL_CAP];
  endproperty
  a_cap_flag: assert property (p_cap_flag)
    else $error("capture stored without its flag");

  property p_irq;
    ##1 (|(s.flags & s.mask)) |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked flag without interrupt");

  property p_top8;
    mode == 4'h5 && tick_io && s.count == tbc_pkg::TOP_8 && !cnt_wr |=> s.count == tbc_pkg::LOWEST_COUNT;
  endproperty
  a_top8: assert property (p_top8)
    else $error("fixed top not honoured");

  property p_max;
    mode == 4'h0 && tick_io && s.count == tbc_pkg::MAX_COUNT && !cnt_wr
      |=> s.count == tbc_pkg::LOWEST_COUNT && s.flags[tbc_pkg::FL_OVF];
  endproperty
  a_max: assert property (p_max)
    else $error("wrap at maximum lost or overflow flag missing");

  property p_match;
    mode == 4'h0 && tick_io && s.count == s.cmp_a |=> s.flags[tbc_pkg::FL_CMA] [*2];
  endproperty
  a_match: assert property (p_match)
    else $error("compare match did not set flag");

endmodule // tbc_timer16

// File: tbc_cpu_model.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// cpu side model: byte-wide register accesses over ahb-lite
// ---------------------------------------------------------------
module tbc_cpu_model (
  // clock
  input wire logic hclk,
  // ahb-lite master side
  output tbc_pkg::tbc_ahb_req_t ahb_req,
  input wire tbc_pkg::tbc_ahb_rsp_t ahb_rsp
);
  tbc_pkg::tbc_ahb_req_t r;

  // single slave, so the bus hready is the slave's own hreadyout
  always_comb begin
    ahb_req = r;
    ahb_req.hready = ahb_rsp.hreadyout;
  end

  // idle bus at time zero
  initial begin
    r = '0;
    r.hsize = tbc_pkg::HSIZE_WORD;
  end

  // one whole-word transfer, address then data phase, each waits for hreadyout
  task automatic xfer(input logic wr, input logic [3:0] ix, input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    r.hsel <= 1'b1;
    r.htrans <= 2'h2;
    r.hwrite <= wr;
    r.haddr <= {26'h0, ix, 2'h0};
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    r.hsel <= 1'b0;
    r.htrans <= 2'h0;
    r.hwdata <= {24'h0, d};
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    q = ahb_rsp.hrdata[7:0];
    // released data line must not keep showing the last value
    r.hwdata <= ~{24'h0, d};
  endtask

  task automatic wr8(input logic [3:0] ix, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, ix, d, q);
  endtask

  task automatic rd8(input logic [3:0] ix, output logic [7:0] q);
    xfer(1'b0, ix, 8'h00, q);
  endtask

  // pairs are issued back to back from one caller, nothing can slip in between
  task automatic wr16(input logic [3:0] hi, input logic [3:0] lo, input logic [15:0] v);
    wr8(hi, v[15:8]);
    wr8(lo, v[7:0]);
  endtask

  task automatic rd16(input logic [3:0] lo, input logic [3:0] hi, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(hi, v[15:8]);
  endtask
endmodule // tbc_cpu_model

// File: tb_top.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// timer testbench
// ---------------------------------------------------------------
module tb_top;
  logic hclk;
  logic hresetn;
  tbc_pkg::tbc_ahb_req_t ahb_req;
  tbc_pkg::tbc_ahb_rsp_t ahb_rsp;
  logic ext_tick;
  logic cap_pin;
  logic cmp_out;
  logic wave_a;
  logic wave_b;
  logic irq;
  integer num_errors;
  integer comparisons;
  integer cycles;
  integer seed;
  logic [15:0] v;
  logic [15:0] w;
  logic [7:0] b;
  logic [3:0] rst_ix [6];
  logic [3:0] m;

  tbc_timer16 u_tbc_timer16 (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .external_tick_pin(ext_tick), .capture_input_pin(cap_pin), .comparator_output(cmp_out),
    .wave_out_a(wave_a), .wave_out_b(wave_b), .irq(irq));
  tbc_cpu_model u_tbc_cpu_model (.hclk(hclk), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp));

  // 40 mhz clock
  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    if (a !== e) begin
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
      num_errors = num_errors + 1;
    end
    comparisons = comparisons + 1;
  endtask

  task automatic r8(input logic [3:0] ix, input logic [7:0] e);
    logic [7:0] q;
    u_tbc_cpu_model.rd8(ix, q);
    chk({8'h00, e}, {8'h00, q});
  endtask

  task automatic r16(input logic [3:0] lo, input logic [3:0] hi, input logic [15:0] e);
    logic [15:0] q;
    u_tbc_cpu_model.rd16(lo, hi, q);
    chk(e, q);
  endtask

  // mode splits over both control registers, tick select sits below
  task automatic set_mode(input logic [3:0] md, input logic [2:0] cs);
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLA, {6'h00, md[1:0]});
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLB, {3'h0, md[3:2], cs});
  endtask

  function automatic logic [15:0] exp_top(input logic [3:0] md, input logic [15:0] ca);
    case (md)
      4'h1, 4'h5: exp_top = 16'h00ff;
      4'h2, 4'h6: exp_top = 16'h01ff;
      4'h3, 4'h7: exp_top = 16'h03ff;
      4'h4, 4'h9, 4'hb, 4'hf: exp_top = ca;
      4'h8, 4'ha, 4'hc, 4'he: exp_top = 16'h0007;
      default: exp_top = 16'hffff;
    endcase
  endfunction

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    seed = 32'h688c7520;
    hresetn = 1'b0;
    ext_tick = 1'b0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    rst_ix = '{tbc_pkg::IX_CTLA, tbc_pkg::IX_CTLB, tbc_pkg::IX_FLG, tbc_pkg::IX_MSK, tbc_pkg::IX_CNTL,
      tbc_pkg::IX_NONE};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_ix[i]) r8(rst_ix[i], 8'h00);
    u_tbc_cpu_model.wr8(tbc_pkg::IX_NONE, 8'hff);
    r8(tbc_pkg::IX_NONE, 8'h00);
    chk(16'h0, {15'h0, ahb_rsp.hresp});
    // control registers with random bytes, tick kept stopped
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLA, b);
      r8(tbc_pkg::IX_CTLA, b);
      u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLB, {b[7:3], 3'h0});
      r8(tbc_pkg::IX_CTLB, {b[7:3], 3'h0});
    end
    set_mode(4'h0, tbc_pkg::CS_STOP);
    // full word through the latch, counter idle while stopped
    v = 16'($random(seed));
    u_tbc_cpu_model.wr16(tbc_pkg::IX_CNTH, tbc_pkg::IX_CNTL, v);
    repeat (20) @(posedge hclk);
    r16(tbc_pkg::IX_CNTL, tbc_pkg::IX_CNTH, v);
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CNTH, ~v[15:8]);
    r16(tbc_pkg::IX_CNTL, tbc_pkg::IX_CNTH, v);
    // compare reads leave the shared latch alone
    w = 16'($random(seed));
    b = ~w[15:8];
    u_tbc_cpu_model.wr16(tbc_pkg::IX_CAH, tbc_pkg::IX_CAL, w);
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CNTH, b);
    r8(tbc_pkg::IX_CAH, w[15:8]);
    r8(tbc_pkg::IX_CAL, w[7:0]);
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CBL, 8'h5a);
    r16(tbc_pkg::IX_CBL, tbc_pkg::IX_CBH, {b, 8'h5a});
    // overflow and both compare flags from one run across the maximum
    u_tbc_cpu_model.wr16(tbc_pkg::IX_CAH, tbc_pkg::IX_CAL, 16'h0010);
    u_tbc_cpu_model.wr16(tbc_pkg::IX_CBH, tbc_pkg::IX_CBL, 16'h0020);
    u_tbc_cpu_model.wr16(tbc_pkg::IX_CNTH, tbc_pkg::IX_CNTL, 16'hfff0);
    r8(tbc_pkg::IX_FLG, 8'h00);
    // both channels set their pin on match, so a dead waveform path shows
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLA, {tbc_pkg::COM_SET, tbc_pkg::COM_SET, 4'h0});
    u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLB, {5'h00, tbc_pkg::CS_IO});
    repeat (60) @(posedge hclk);
    set_mode(4'h0, tbc_pkg::CS_STOP);
    repeat (2) @(posedge hclk);
    chk(16'h3, {14'h0, wave_a, wave_b});
    chk(16'h0, {15'h0, irq});
    u_tbc_cpu_model.wr8(tbc_pkg::IX_MSK, 8'h07);
    repeat (2) @(posedge hclk);
    chk(16'h1, {15'h0, irq});
    r8(tbc_pkg::IX_FLG, 8'h07);
    repeat (2) @(posedge hclk);
    chk(16'h0, {15'h0, irq});
    r8(tbc_pkg::IX_FLG, 8'h00);
    // fixed, compare a and capture tops, sampled at random moments
    u_tbc_cpu_model.wr16(tbc_pkg::IX_CAH, tbc_pkg::IX_CAL, 16'h0005);
    for (int k = 1; k < 16; k++) begin
      m = 4'(k);
      set_mode(m, tbc_pkg::CS_STOP);
      // capture only takes a write in the modes where it sets the period
      u_tbc_cpu_model.wr16(tbc_pkg::IX_CPH, tbc_pkg::IX_CPL, 16'h0007);
      r16(tbc_pkg::IX_CPL, tbc_pkg::IX_CPH, (k >= 8) ? 16'h0007 : 16'h0000);
      u_tbc_cpu_model.wr16(tbc_pkg::IX_CNTH, tbc_pkg::IX_CNTL, 16'h0000);
      set_mode(m, tbc_pkg::CS_IO);
      u_tbc_cpu_model.wr16(tbc_pkg::IX_CNTH, tbc_pkg::IX_CNTL, 16'h0000);
      for (int j = 0; j < 4; j++) begin
        repeat (($random(seed) & 63) + 1) @(posedge hclk);
        u_tbc_cpu_model.rd16(tbc_pkg::IX_CNTL, tbc_pkg::IX_CNTH, v);
        chk(16'h1, {15'h0, v <= exp_top(m, 16'h0005)});
      end
    end
    // external tick on either edge counts each pulse once
    for (int k = 0; k < 2; k++) begin
      set_mode(4'h0, tbc_pkg::CS_STOP);
      u_tbc_cpu_model.wr16(tbc_pkg::IX_CNTH, tbc_pkg::IX_CNTL, 16'h0000);
      set_mode(4'h0, k == 0 ? tbc_pkg::CS_RISE : tbc_pkg::CS_FALL);
      repeat (5) begin
        ext_tick <= 1'b1;
        repeat (4) @(posedge hclk);
        ext_tick <= 1'b0;
        repeat (4) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      set_mode(4'h0, tbc_pkg::CS_STOP);
      r16(tbc_pkg::IX_CNTL, tbc_pkg::IX_CNTH, 16'h0005);
    end
    // capture from pin, then from comparator, on rising edges only
    for (int k = 0; k < 2; k++) begin
      v = 16'($random(seed));
      u_tbc_cpu_model.wr16(tbc_pkg::IX_CNTH, tbc_pkg::IX_CNTL, v);
      // the comparator pass also runs the capture filter
      u_tbc_cpu_model.wr8(tbc_pkg::IX_CTLB, {k[0], 1'b1, k[0], 5'h00});
      u_tbc_cpu_model.wr8(tbc_pkg::IX_MSK, 8'h08);
      repeat (10) @(posedge hclk);
      u_tbc_cpu_model.rd8(tbc_pkg::IX_FLG, b);
      if (k == 0) cap_pin <= 1'b1;
      else cmp_out <= 1'b1;
      repeat (10) @(posedge hclk);
      chk(16'h1, {15'h0, irq});
      r8(tbc_pkg::IX_FLG, 8'h08);
      r16(tbc_pkg::IX_CPL, tbc_pkg::IX_CPH, v);
      cap_pin <= 1'b0;
      cmp_out <= 1'b0;
      repeat (10) @(posedge hclk);
      r8(tbc_pkg::IX_FLG, 8'h00);
    end
    close_out();
  end
endmodule // tb_top
